// ===== src/interrupt_status_mask_regs.sv
// Two-level interrupt status and mask registers with Avalon-MM slave
`timescale 1ns/1ps

module interrupt_status_mask_regs
   import irq_regs_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // Avalon-MM slave
   input  wire logic [31:0] address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic [31:0]      readdata_o,
   output logic [1:0]       response_o,
   output logic             waitrequest_o,
   // Peripheral request levels
   input  wire logic [31:0] gpio_irq_i,
   input  wire logic        debug_serial_irq_i,
   input  wire logic [4:0]  infrared_irq_i,
   input  wire logic        pci_irq_i,
   input  wire logic        scu_irq_i,
   input  wire logic [6:0]  clocked_serial_irq_i,
   input  wire logic        bus_unit_irq_i,
   input  wire logic        tick_counter_irq_i,
   input  wire logic        led_irq_i,
   input  wire logic        long_timer2_irq_i,
   input  wire logic        battery_irq_i,
   // Core requests
   output logic             core_general_irq_o,
   output logic             nmi_o,
   output logic             long_timer2_core_irq_o,
   // Infrared DMA control
   output logic             ir_dma_stop_o
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [15:0]           status_q [NUM_GROUPS];
   logic [15:0]           mask_q   [NUM_GROUPS];
   logic [15:0]           raw      [NUM_GROUPS];
   logic [NUM_GROUPS-1:0] pending;
   logic [15:0]           level1_status_two;
   logic [15:0]           level1_mask_two;
   logic [15:0]           battery_irq_route;
   logic [15:0]           software_irq_set;
   logic [15:0]           ir_dma_page_control_reg;
   logic                  battery_q;
   logic                  ack;
   logic                  req;
   logic                  wr_go;
   logic                  rd_load;
   logic [15:0]           rd_word;
   logic                  rd_hit;
   logic [15:0]           next_level1_status_two;
   logic                  next_general_irq;
   logic                  next_dma_stop;

   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [1:0]  be);
      return {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
   endfunction

   // ****************************************************************
   // Avalon handshake: one wait cycle per access
   // ****************************************************************
   assign req           = read_i | write_i;
   assign waitrequest_o = req & ~ack;
   assign wr_go         = write_i & ack;
   assign rd_load       = read_i & ~ack;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // ****************************************************************
   // Level-2 groups
   // ****************************************************************
   assign raw[G_GPIO_LOW]   = gpio_irq_i[15:0];
   assign raw[G_GPIO_HIGH]  = gpio_irq_i[31:16];
   assign raw[G_DEBUG_SER]  = {4'h0, debug_serial_irq_i, 11'h000};
   assign raw[G_INFRARED]   = {11'h000, infrared_irq_i};
   assign raw[G_PCI]        = {15'h0000, pci_irq_i};
   assign raw[G_SCU]        = {15'h0000, scu_irq_i};
   assign raw[G_CLK_SERIAL] = {9'h000, clocked_serial_irq_i};
   assign raw[G_BUS_UNIT]   = {15'h0000, bus_unit_irq_i};

   for (genvar g = 0; g < NUM_GROUPS; g++) begin : gen_group
      // Status follows the sources only; bus writes never reach it
      always_ff @(posedge mclk_i) begin
         if (!rst_n_i) begin
            status_q[g] <= REG_RESET;
         end else begin
            status_q[g] <= raw[g] & GRP_VALID[g];
         end
      end

      always_ff @(posedge mclk_i) begin
         if (!rst_n_i) begin
            mask_q[g] <= REG_RESET;
         end else if (wr_go && address_i == addr_of(GRP_MASK_IDX[g])) begin
            // Reserved positions stay zero
            mask_q[g] <= merge(mask_q[g], writedata_i[15:0], byteenable_i[1:0])
                         & GRP_VALID[g];
         end
      end

      masked_group u_group (
         .status_i  (status_q[g]),
         .mask_i    (mask_q[g]),
         .pending_o (pending[g])
      );

      AST_MASK_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         (mask_q[g] & ~GRP_VALID[g]) == 16'h0000)
         else $error("reserved mask bit set");
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         level1_mask_two <= REG_RESET;
      end else if (wr_go && address_i == addr_of(L1_MASK_TWO_IDX)) begin
         level1_mask_two <= merge(level1_mask_two, writedata_i[15:0], byteenable_i[1:0])
                            & L1_TWO_VALID;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         battery_irq_route <= REG_RESET;
      end else if (wr_go && address_i == addr_of(BATTERY_ROUTE_IDX)) begin
         battery_irq_route <= merge(battery_irq_route, writedata_i[15:0], byteenable_i[1:0])
                              & ROUTE_VALID;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         software_irq_set <= REG_RESET;
      end else if (wr_go && address_i == addr_of(SOFTWARE_IRQ_IDX)) begin
         software_irq_set <= merge(software_irq_set, writedata_i[15:0], byteenable_i[1:0])
                             & SOFT_VALID;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ir_dma_page_control_reg <= REG_RESET;
      end else if (wr_go && address_i == addr_of(DMA_PAGE_CTRL_IDX)) begin
         ir_dma_page_control_reg <= merge(ir_dma_page_control_reg, writedata_i[15:0],
                                          byteenable_i[1:0]) & DMA_CTRL_VALID;
      end
   end

   // ****************************************************************
   // Level-1 status two
   // ****************************************************************
   always_comb begin
      next_level1_status_two                         = REG_RESET;
      next_level1_status_two[BUS_UNIT_IRQ_BIT]       = pending[G_BUS_UNIT];
      next_level1_status_two[CLOCKED_SERIAL_IRQ_BIT] = pending[G_CLK_SERIAL];
      next_level1_status_two[SCU_SOURCE_IRQ_BIT]     = pending[G_SCU];
      next_level1_status_two[PCI_LEVEL1_IRQ_BIT]     = pending[G_PCI];
      next_level1_status_two[DEBUG_SERIAL_L1_BIT]    = pending[G_DEBUG_SER];
      next_level1_status_two[INFRARED_LEVEL1_BIT]    = pending[G_INFRARED];
      next_level1_status_two[TICK_COUNTER_IRQ_BIT]   = tick_counter_irq_i;
      next_level1_status_two[LED_IRQ_BIT]            = led_irq_i;
      next_level1_status_two[LONG_TIMER2_IRQ_BIT]    = long_timer2_irq_i;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         level1_status_two <= REG_RESET;
         battery_q         <= 1'b0;
      end else begin
         level1_status_two <= next_level1_status_two;
         battery_q         <= battery_irq_i;
      end
   end

   // ****************************************************************
   // Core request outputs
   // ****************************************************************
   always_comb begin
      next_general_irq = (|(level1_status_two & level1_mask_two
                            & ~(16'h0001 << LONG_TIMER2_IRQ_BIT)))
                         | pending[G_GPIO_LOW] | pending[G_GPIO_HIGH]
                         | (|software_irq_set)
                         | (battery_q & battery_irq_route[BATTERY_ROUTE_SELECT]);
   end

   always_comb begin
      next_dma_stop = status_q[G_INFRARED][IR_RX_TWO_PAGE_BIT]
                    | status_q[G_INFRARED][IR_TX_TWO_PAGE_BIT]
                    | (ir_dma_page_control_reg[IR_ONE_PAGE_IRQ_CTRL]
                       & (status_q[G_INFRARED][IR_RX_ONE_PAGE_BIT]
                          | status_q[G_INFRARED][IR_TX_ONE_PAGE_BIT]));
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         core_general_irq_o     <= 1'b0;
         nmi_o                  <= 1'b0;
         long_timer2_core_irq_o <= 1'b0;
         ir_dma_stop_o          <= 1'b0;
      end else begin
         core_general_irq_o     <= next_general_irq;
         nmi_o                  <= battery_q & ~battery_irq_route[BATTERY_ROUTE_SELECT];
         long_timer2_core_irq_o <= level1_status_two[LONG_TIMER2_IRQ_BIT]
                                   & level1_mask_two[LONG_TIMER2_IRQ_BIT];
         ir_dma_stop_o          <= next_dma_stop;
      end
   end

   // ****************************************************************
   // Register read
   // ****************************************************************
   always_comb begin
      rd_word = REG_RESET;
      rd_hit  = 1'b0;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         if (address_i == addr_of(GRP_STAT_IDX[g])) begin
            rd_word = status_q[g];
            rd_hit  = 1'b1;
         end else if (address_i == addr_of(GRP_MASK_IDX[g])) begin
            rd_word = mask_q[g];
            rd_hit  = 1'b1;
         end
      end
      if (address_i == addr_of(L1_STATUS_TWO_IDX)) begin
         rd_word = level1_status_two;
         rd_hit  = 1'b1;
      end else if (address_i == addr_of(L1_MASK_TWO_IDX)) begin
         rd_word = level1_mask_two;
         rd_hit  = 1'b1;
      end else if (address_i == addr_of(BATTERY_ROUTE_IDX)) begin
         rd_word = battery_irq_route;
         rd_hit  = 1'b1;
      end else if (address_i == addr_of(SOFTWARE_IRQ_IDX)) begin
         rd_word = software_irq_set;
         rd_hit  = 1'b1;
      end else if (address_i == addr_of(DMA_PAGE_CTRL_IDX)) begin
         rd_word = ir_dma_page_control_reg;
         rd_hit  = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         readdata_o <= 32'h0000_0000;
         response_o <= RESP_OKAY;
      end else if (rd_load) begin
         readdata_o <= {16'h0000, rd_word};
         response_o <= rd_hit ? RESP_OKAY : RESP_DECODEERROR;
      end else if (write_i && !ack) begin
         response_o <= (rd_hit || address_i == addr_of(DMA_PAGE_CTRL_IDX))
                       ? RESP_OKAY : RESP_DECODEERROR;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_req_waiting;
      req && waitrequest_o;
   endsequence

   sequence s_req_granted;
      !waitrequest_o;
   endsequence

   sequence s_soft_write;
      wr_go && address_i == addr_of(SOFTWARE_IRQ_IDX) && byteenable_i[0];
   endsequence

   AST_ONE_WAIT_CYCLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_req_waiting |=> s_req_granted)
      else $error("access not granted after one wait cycle");

   AST_MASKS_CLEARED_AT_RESET: assert property (@(posedge mclk_i)
      !$past(rst_n_i) |-> (level1_mask_two == 16'h0000 && mask_q[G_GPIO_LOW] == 16'h0000
                           && mask_q[G_INFRARED] == 16'h0000))
      else $error("mask not zero after reset");

   AST_BATTERY_TO_NMI: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (battery_q && !battery_irq_route[0]) |=> nmi_o)
      else $error("battery request not on NMI");

   AST_BATTERY_TO_GENERAL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (battery_q && battery_irq_route[0]) |=> (core_general_irq_o && !nmi_o))
      else $error("battery request not on general request");

   AST_SOFTWARE_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_soft_write |=> (software_irq_set[3:0] == $past(writedata_i[3:0]))
      ##1 (core_general_irq_o || $past(software_irq_set[3:0]) == 4'h0))
      else $error("software request bits not written");

   AST_TWO_PAGE_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (status_q[G_INFRARED][3] || status_q[G_INFRARED][2]) |=> ir_dma_stop_o)
      else $error("two-page flag did not stop DMA");

   AST_ONE_PAGE_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (status_q[G_INFRARED][3:0] != 4'h0) |=>
      (ir_dma_stop_o == ($past(status_q[G_INFRARED][3:2]) != 2'b00
                        || $past(ir_dma_page_control_reg[0]))))
      else $error("one-page stop does not follow control bit");

   AST_PCI_LEVEL1: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (status_q[G_PCI][0] && mask_q[G_PCI][0]) |=> level1_status_two[6])
      else $error("PCI request not reported at level 1");

   AST_GENERAL_FROM_LEVEL1: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (level1_status_two[9:1] & level1_mask_two[9:1]) != 9'h000 |=> core_general_irq_o)
      else $error("enabled level-1 request missing on general request");

   AST_TIMER2_OWN_LINE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (level1_status_two[0] && level1_mask_two[0]) |=> long_timer2_core_irq_o)
      else $error("long timer two request lost");

endmodule

// ===== src/irq_regs_pkg.sv
// Register map, field positions and reset values of the interrupt status and mask block
package irq_regs_pkg;

   // ****************************************************************
   // Level-2 groups
   // ****************************************************************
   localparam int NUM_GROUPS   = 8;
   localparam int G_GPIO_LOW   = 0;
   localparam int G_GPIO_HIGH  = 1;
   localparam int G_DEBUG_SER  = 2;
   localparam int G_INFRARED   = 3;
   localparam int G_PCI        = 4;
   localparam int G_SCU        = 5;
   localparam int G_CLK_SERIAL = 6;
   localparam int G_BUS_UNIT   = 7;

   // Register indices; byte address is four times the index
   localparam logic [31:0] GRP_STAT_IDX [NUM_GROUPS] = '{
      32'h0F00_0088, 32'h0F00_00A2, 32'h0F00_008A, 32'h0F00_00A4,
      32'h0F00_00AC, 32'h0F00_00AE, 32'h0F00_00B0, 32'h0F00_00B8};
   localparam logic [31:0] GRP_MASK_IDX [NUM_GROUPS] = '{
      32'h0F00_0094, 32'h0F00_00A8, 32'h0F00_0096, 32'h0F00_00AA,
      32'h0F00_00B2, 32'h0F00_00B4, 32'h0F00_00B6, 32'h0F00_00BA};
   // Implemented bit positions per group; all others are reserved
   localparam logic [15:0] GRP_VALID [NUM_GROUPS] = '{
      16'hBFFF, 16'hFFFF, 16'h0800, 16'h001F,
      16'h0001, 16'h0001, 16'h007F, 16'h0001};

   // ****************************************************************
   // Level-1 and control registers
   // ****************************************************************
   localparam logic [31:0] BATTERY_ROUTE_IDX  = 32'h0F00_0098;
   localparam logic [31:0] SOFTWARE_IRQ_IDX   = 32'h0F00_009A;
   localparam logic [31:0] L1_STATUS_TWO_IDX  = 32'h0F00_00A0;
   localparam logic [31:0] L1_MASK_TWO_IDX    = 32'h0F00_00A6;
   localparam logic [31:0] DMA_PAGE_CTRL_IDX  = 32'h0F00_0844;

   localparam logic [15:0] L1_TWO_VALID       = 16'h03FB;
   localparam logic [15:0] ROUTE_VALID        = 16'h0001;
   localparam logic [15:0] SOFT_VALID         = 16'h000F;
   localparam logic [15:0] DMA_CTRL_VALID     = 16'h0001;
   localparam logic [15:0] REG_RESET          = 16'h0000;

   // Level-1 status two bit positions
   localparam int BUS_UNIT_IRQ_BIT       = 9;
   localparam int CLOCKED_SERIAL_IRQ_BIT = 8;
   localparam int SCU_SOURCE_IRQ_BIT     = 7;
   localparam int PCI_LEVEL1_IRQ_BIT     = 6;
   localparam int DEBUG_SERIAL_L1_BIT    = 5;
   localparam int INFRARED_LEVEL1_BIT    = 4;
   localparam int TICK_COUNTER_IRQ_BIT   = 3;
   localparam int LED_IRQ_BIT            = 1;
   localparam int LONG_TIMER2_IRQ_BIT    = 0;

   // Other field positions
   localparam int BATTERY_ROUTE_SELECT   = 0;
   localparam int IR_RX_TWO_PAGE_BIT     = 3;
   localparam int IR_TX_TWO_PAGE_BIT     = 2;
   localparam int IR_RX_ONE_PAGE_BIT     = 1;
   localparam int IR_TX_ONE_PAGE_BIT     = 0;
   localparam int IR_ONE_PAGE_IRQ_CTRL   = 0;

   // Avalon response codes
   localparam logic [1:0] RESP_OKAY        = 2'b00;
   localparam logic [1:0] RESP_DECODEERROR = 2'b11;

   function automatic logic [31:0] addr_of(input logic [31:0] idx);
      return {idx[29:0], 2'b00};
   endfunction

endpackage

// ===== src/masked_group.sv
// One level-2 group: status ANDed with mask, gathered into one request
`timescale 1ns/1ps
module masked_group (
   // Level-2 state
   input  wire logic [15:0] status_i,
   input  wire logic [15:0] mask_i,
   // Gathered request
   output logic             pending_o
);
   assign pending_o = |(status_i & mask_i);
endmodule

// ===== verification/interrupt_status_mask_regs_bench.sv
// Self-checking bench for the interrupt status and mask registers
`timescale 1ns/1ps
module interrupt_status_mask_regs_bench import irq_regs_pkg::*;;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        rd_en = 1'b0;
   logic        wr_en = 1'b0;
   logic [31:0] addr = '0;
   logic [31:0] wdata = '0;
   logic [3:0]  be_q = '0;
   logic [51:0] src = '0;
   logic [51:0] req;
   logic [31:0] readdata_o;
   logic [1:0]  response_o;
   logic        waitrequest_o, core_general_irq_o, nmi_o, long_timer2_core_irq_o, ir_dma_stop_o;
   logic [15:0] m_mask [NUM_GROUPS];
   logic [15:0] m_l1m, m_route, m_soft, m_dma;
   logic [31:0] regs [$];
   int          n_mismatch = 0;
   int          compares = 0;

   initial forever #4 mclk_i = ~mclk_i;

   irq_source_model i_irq_source_model (.mclk_i(mclk_i), .load_i(1'b1), .levels_i(src),
      .req_o(req));
   interrupt_status_mask_regs i_interrupt_status_mask_regs (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .address_i(addr), .read_i(rd_en), .write_i(wr_en), .writedata_i(wdata),
      .byteenable_i(be_q), .readdata_o(readdata_o), .response_o(response_o),
      .waitrequest_o(waitrequest_o), .gpio_irq_i(req[31:0]), .debug_serial_irq_i(req[32]),
      .infrared_irq_i(req[37:33]), .pci_irq_i(req[38]), .scu_irq_i(req[39]),
      .clocked_serial_irq_i(req[46:40]), .bus_unit_irq_i(req[47]),
      .tick_counter_irq_i(req[48]), .led_irq_i(req[49]), .long_timer2_irq_i(req[50]),
      .battery_irq_i(req[51]), .core_general_irq_o(core_general_irq_o), .nmi_o(nmi_o),
      .long_timer2_core_irq_o(long_timer2_core_irq_o), .ir_dma_stop_o(ir_dma_stop_o));

   // ****************************************************************
   // Reference model
   // ****************************************************************
   function automatic logic [15:0] gstat(int g);
      logic [15:0] v;
      case (g)
         G_GPIO_LOW:   v = src[15:0];
         G_GPIO_HIGH:  v = src[31:16];
         G_DEBUG_SER:  v = {4'h0, src[32], 11'h000};
         G_INFRARED:   v = {11'h000, src[37:33]};
         G_PCI:        v = {15'h0000, src[38]};
         G_SCU:        v = {15'h0000, src[39]};
         G_CLK_SERIAL: v = {9'h000, src[46:40]};
         default:      v = {15'h0000, src[47]};
      endcase
      return v & GRP_VALID[g];
   endfunction

   function automatic logic pend(int g);
      return |(gstat(g) & m_mask[g]);
   endfunction

   function automatic logic [15:0] l1();
      return {6'h00, pend(G_BUS_UNIT), pend(G_CLK_SERIAL), pend(G_SCU), pend(G_PCI),
              pend(G_DEBUG_SER), pend(G_INFRARED), src[48], 1'b0, src[49], src[50]};
   endfunction

   function automatic logic [17:0] exp_rd(logic [31:0] idx);
      for (int g = 0; g < NUM_GROUPS; g++) begin
         if (idx == GRP_STAT_IDX[g]) return {RESP_OKAY, gstat(g)};
         if (idx == GRP_MASK_IDX[g]) return {RESP_OKAY, m_mask[g]};
      end
      case (idx)
         L1_STATUS_TWO_IDX: return {RESP_OKAY, l1()};
         L1_MASK_TWO_IDX:   return {RESP_OKAY, m_l1m};
         BATTERY_ROUTE_IDX: return {RESP_OKAY, m_route};
         SOFTWARE_IRQ_IDX:  return {RESP_OKAY, m_soft};
         DMA_PAGE_CTRL_IDX: return {RESP_OKAY, m_dma};
         default:           return {RESP_DECODEERROR, 16'h0000};
      endcase
   endfunction

   // Writable and readable positions; stimulus keeps reserved bits at zero
   function automatic logic [15:0] ok_bits(logic [31:0] idx);
      for (int g = 0; g < NUM_GROUPS; g++) begin
         if (idx == GRP_STAT_IDX[g] || idx == GRP_MASK_IDX[g]) return GRP_VALID[g];
      end
      case (idx)
         L1_STATUS_TWO_IDX: return L1_TWO_VALID;
         L1_MASK_TWO_IDX:   return L1_TWO_VALID;
         BATTERY_ROUTE_IDX: return ROUTE_VALID;
         SOFTWARE_IRQ_IDX:  return SOFT_VALID;
         DMA_PAGE_CTRL_IDX: return DMA_CTRL_VALID;
         default:           return 16'hFFFF;
      endcase
   endfunction

   function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] d, logic [3:0] be,
                                         logic [15:0] ok);
      return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]} & ok;
   endfunction

   task automatic model_wr(logic [31:0] idx, logic [15:0] d, logic [3:0] be);
      for (int g = 0; g < NUM_GROUPS; g++) begin
         if (idx == GRP_MASK_IDX[g]) m_mask[g] = merge(m_mask[g], d, be, GRP_VALID[g]);
      end
      if (idx == L1_MASK_TWO_IDX) m_l1m = merge(m_l1m, d, be, L1_TWO_VALID);
      if (idx == BATTERY_ROUTE_IDX) m_route = merge(m_route, d, be, ROUTE_VALID);
      if (idx == SOFTWARE_IRQ_IDX) m_soft = merge(m_soft, d, be, SOFT_VALID);
      if (idx == DMA_PAGE_CTRL_IDX) m_dma = merge(m_dma, d, be, DMA_CTRL_VALID);
   endtask

   // ****************************************************************
   // Bus access and comparisons
   // ****************************************************************
   task automatic fail(string msg);
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
   endtask

   task automatic cmp_rd(logic [31:0] idx, logic [33:0] got);
      logic [17:0] e;
      e = exp_rd(idx);
      compares++;
      if (got !== {e[17:16], 16'h0000, e[15:0]}) begin
         fail($sformatf("read %h got %h", idx, got));
      end
   endtask

   task automatic cmp_out();
      logic [15:0] s;
      logic [3:0]  e;
      s = l1();
      e[3] = |(s[9:1] & m_l1m[9:1]) | pend(G_GPIO_LOW) | pend(G_GPIO_HIGH) | (|m_soft)
             | (src[51] & m_route[0]);
      e[2] = src[51] & !m_route[0];
      e[1] = s[0] & m_l1m[0];
      e[0] = src[36] | src[35] | (m_dma[0] & (src[34] | src[33]));
      repeat (4) @(posedge mclk_i);
      @(negedge mclk_i);
      compares++;
      if ({core_general_irq_o, nmi_o, long_timer2_core_irq_o, ir_dma_stop_o} !== e)
         fail($sformatf("core requests exp %b", e));
   endtask

   task automatic bus(logic wr, logic [31:0] idx, logic [15:0] d, logic [3:0] be);
      int          n;
      logic [33:0] got;
      @(posedge mclk_i);
      addr <= {idx[29:0], 2'b00};
      wdata <= {16'hA5A5, d};
      be_q <= be;
      rd_en <= !wr;
      wr_en <= wr;
      n = 0;
      // Waitrequest and read data are taken at the same rising edge
      do begin
         @(posedge mclk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 50);
      got = {response_o, readdata_o};
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      if (n >= 50) fail("no answer");
      if (wr) model_wr(idx, d, be);
      else cmp_rd(idx, got);
   endtask

   task automatic do_reset();
      rst_n_i <= 1'b0;
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      m_mask = '{default: '0};
      {m_l1m, m_route, m_soft, m_dma} = '0;
      @(posedge mclk_i);
   endtask

   task automatic stop_test();
      $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      repeat (60000) @(posedge mclk_i);
      fail("watchdog expired");
      stop_test();
   end

   initial begin
      void'($urandom(69));
      for (int g = 0; g < NUM_GROUPS; g++) begin
         regs.push_back(GRP_STAT_IDX[g]);
         regs.push_back(GRP_MASK_IDX[g]);
      end
      regs = {regs, L1_STATUS_TWO_IDX, L1_MASK_TWO_IDX, BATTERY_ROUTE_IDX, SOFTWARE_IRQ_IDX,
              DMA_PAGE_CTRL_IDX, 32'h0F00_00BC};
      do_reset();
      for (int pass = 0; pass < 2; pass++) begin
         foreach (regs[i]) bus(1'b0, regs[i], 16'h0000, 4'h0);
         $display("Test reset_values pass %0d done", pass);
         for (int k = 0; k < 24; k++) begin
            src <= 52'({$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom});
            foreach (regs[i]) bus(1'b1, regs[i], 16'($urandom & $urandom) & ok_bits(regs[i]),
                                  4'($urandom));
            cmp_out();
            foreach (regs[i]) bus(1'b0, regs[i], 16'h0000, 4'h0);
            // Same reads also
            // and
         end
         $display("Test random_traffic pass %0d done", pass);
         do_reset();
      end
      stop_test();
   end
endmodule

// ===== verification/irq_source_model.sv
// Peripheral units that raise request levels into the interrupt block
`timescale 1ns/1ps
module irq_source_model (
   // Clock
   input  wire logic        mclk_i,
   // New levels from the bench
   input  wire logic        load_i,
   input  wire logic [51:0] levels_i,
   // Request levels towards the block
   output logic [51:0]      req_o
);
   // Levels only move on a clock edge, like a synchronous peripheral
   always_ff @(posedge mclk_i) begin
      if (load_i) begin
         req_o <= levels_i;
      end
   end
endmodule
